//--- rcc_defs.svh
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

// register map (byte address of the single word)
`define RCC_REG_OFFSET        8'h00
`define RCC_WORD_BITS         2

// reset_cause_control bit positions
`define RCC_BIT_PRIO_EN       7
`define RCC_BIT_SOFT_BOR_EN   6
`define RCC_BIT_UNUSED        5
`define RCC_BIT_RESET_INSTR   4
`define RCC_BIT_WDT_TIMEOUT   3
`define RCC_BIT_POWERDOWN     2
`define RCC_BIT_POWERON       1
`define RCC_BIT_BROWNOUT      0

// values loaded by a power-on or brown-out reset
`define RCC_RST_PRIO_EN       1'b0
`define RCC_RST_RESET_INSTR   1'b1
`define RCC_RST_WDT_TIMEOUT   1'b1
`define RCC_RST_POWERDOWN     1'b1
`define RCC_RST_POWERON       1'b0
`define RCC_RST_BROWNOUT      1'b0

// brownout_mode_field position in brownout_config_byte and its codes
`define BOR_MODE_MSB          2
`define BOR_MODE_LSB          1
`define BOR_MODE_OFF          2'h0
`define BOR_MODE_SOFT         2'h1
`define BOR_MODE_NOSLEEP      2'h2
`define BOR_MODE_ALWAYS       2'h3

// timing
`define CLK_PERIOD_NS         100
`define MASTER_CLEAR_PIN_N_FILTER_NS        2000
`define MASTER_CLEAR_PIN_N_FILTER_CYC       ((`MASTER_CLEAR_PIN_N_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOR_QUALIFY_NS        3000
`define BOR_QUALIFY_CYC       ((`BOR_QUALIFY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LFOSC_PERIOD_NS       32000
`define LFOSC_TICK_CYC        (`LFOSC_PERIOD_NS / `CLK_PERIOD_NS)
`define POWER_UP_TIMER_PERIODS          2048

`endif

//--- rcc_pkg.sv
package rcc_pkg;
    typedef logic [7:0] cfg_byte_t;
    typedef logic [1:0] bor_mode_t;
    // reset sequencer: supply resets, then the power-up timer, then run
    typedef enum logic [1:0] {
        S_POWERON,
        S_BROWNOUT,
        S_TIMER,
        S_RUN
    } seq_state_t;
endpackage

//--- power_up_timer_if.sv
interface power_up_timer_if;
    logic restart;
    logic enable;
    logic busy;
    modport ctrl  (output restart, output enable, input busy);
    modport timer (input restart, input enable, output busy);
endinterface

//--- level_qualifier.sv
module level_qualifier #(
    parameter int   LIMIT = 1,
    parameter logic INIT  = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic raw_i,
    output logic      level_o
);
    logic       meta_r;
    logic       sync_r;
    logic       level_r;
    logic [7:0] cnt_r;

    // two-flop synchroniser; meta_r is read by sync_r only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= raw_i;
            sync_r <= meta_r;
        end
    end

    // a new level must stand LIMIT cycles; shorter pulses are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_r <= INIT;
            cnt_r   <= 8'h00;
        end else if (sync_r == level_r) begin
            cnt_r <= 8'h00;
        end else if (cnt_r == 8'(LIMIT - 1)) begin
            level_r <= sync_r;
            cnt_r   <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign level_o = level_r;
endmodule

//--- power_up_timer.sv
`include "rcc_defs.svh"
module power_up_timer #(
    parameter int PERIODS = `POWER_UP_TIMER_PERIODS
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    power_up_timer_if.timer     tif
);
    logic [8:0]  tick_r;
    logic [10:0] period_r;
    logic        busy_r;
    logic        tick_done;

    // low_freq_internal_osc period as a core-clock divider
    assign tick_done = (tick_r == 9'(`LFOSC_TICK_CYC - 1));

    // 11-bit period counter; restart holds it at zero
    always_ff @(posedge clk_i) begin
        if (rst_i || tif.restart) begin
            tick_r   <= 9'h000;
            period_r <= 11'h000;
        end else if (busy_r) begin
            tick_r <= tick_done ? 9'h000 : tick_r + 9'h001;
            if (tick_done) begin
                period_r <= period_r + 11'h001;
            end
        end
    end

    // busy from restart (only when enabled) until the last period ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (tif.restart) begin
            busy_r <= tif.enable;
        end else if (busy_r && tick_done && period_r == 11'(PERIODS - 1)) begin
            busy_r <= 1'b0;
        end
    end

    assign tif.busy = busy_r;
endmodule

//--- reset_cause_and_brownout_control.sv
// Behaviour
// - low five bits of the register record which reset last happened
// - bit 7 enables interrupt priority levels; zero gives single-level mode
// - bit 6 switches brown-out detection only in soft mode, else reads zero
// - reset loads bit 6 with one when config bits [2:1] equal 01
// - bit 4 clears on reset instruction; power-on or software sets it
// - bit 3 read-only; watchdog time-out clears, power-up/clear/sleep set
// - bit 2 read-only; sleep clears it, power-up or watchdog clear sets
// - bit 1 clears on every power-on reset; only software sets it
// - bit 0 clears on brown-out or power-on reset; only software sets it
// - power-on/brown-out values: 1,1,1,0 and brown-out 0; bit 5 reads 0
// - master clear held low resets; filter drops short pulses; pull-up on
// - the master clear pin is never driven by any internal reset
// - master clear disabled means the pin is just a digital input
// - brown-out detection off when mode is 00; holds reset while low
// - power-up timer starts after supply recovers; new brown-out restarts it
// - brown-out enable and power-up timer enable are independent
// - brown-out detector rearms power-on logic below its operating range
// - mode 10 enables detection except during sleep
// - mode 11 enables detection permanently
// - power-up timer counts 2048 low-frequency periods, holding reset
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`include "rcc_defs.svh"
module reset_cause_and_brownout_control #(
    parameter int POWER_UP_TIMER_PERIODS = `POWER_UP_TIMER_PERIODS
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // classic wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // analog monitors, asynchronous
    input  wire logic              por_pulse_i,
    input  wire logic              supply_below_bor_i,
    input  wire logic              supply_below_bor_range_i,
    input  wire logic              master_clear_pin_n_i,
    // core events, same clock
    input  wire logic              watchdog_timeout_i,
    input  wire logic              reset_instr_i,
    input  wire logic              watchdog_clear_instruction_i,
    input  wire logic              sleep_instr_i,
    input  wire logic              sleep_mode_i,
    // configuration fuses
    input  wire rcc_pkg::cfg_byte_t brownout_config_byte_i,
    input  wire logic              master_clear_input_enable_i,
    input  wire logic              power_up_timer_enable_i,
    // outputs
    output logic                   device_reset_o,
    output logic                   priority_levels_enable_o,
    output logic                   brownout_detect_enable_o,
    output logic                   master_clear_pullup_en_o,
    output logic                   master_clear_digital_o
);
    import rcc_pkg::*;

    seq_state_t state_r;
    seq_state_t state_nxt;
    bor_mode_t  brownout_mode_field;
    logic       por_q;
    logic       bor_low_q;
    logic       range_low_q;
    logic       master_clear_pin_n_q;
    logic       por_act;
    logic       bor_act;
    logic       master_clear_pin_n_act;
    logic       int_reset;
    logic       bor_en_nxt;
    logic       bor_en_r;
    logic       ack_r;
    logic [31:0] dat_r;
    logic       req;
    logic       hit;
    logic       bus_write;
    logic       prio_en_r;
    logic       soft_bor_en_r;
    logic       reset_instr_flag_n_r;
    logic       watchdog_timeout_flag_n_r;
    logic       powerdown_flag_n_r;
    logic       poweron_flag_n_r;
    logic       brownout_flag_n_r;
    logic [7:0] rcc_read;
    logic       device_reset_r;
    logic       pullup_r;
    logic       master_clear_pin_n_dig_r;
    power_up_timer_if     ptif ();

    assign brownout_mode_field = brownout_config_byte_i[`BOR_MODE_MSB:`BOR_MODE_LSB];

    // asynchronous monitors pass two flops; pin and brown-out are qualified
    level_qualifier #(.LIMIT(1), .INIT(1'b0)) u_por_q (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (por_pulse_i),
        .level_o (por_q)
    );
    level_qualifier #(.LIMIT(`BOR_QUALIFY_CYC), .INIT(1'b0)) u_bor_q (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (supply_below_bor_i),
        .level_o (bor_low_q)
    );
    level_qualifier #(.LIMIT(1), .INIT(1'b0)) u_range_q (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (supply_below_bor_range_i),
        .level_o (range_low_q)
    );
    level_qualifier #(.LIMIT(`MASTER_CLEAR_PIN_N_FILTER_CYC), .INIT(1'b1)) u_master_clear_pin_n_q (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (master_clear_pin_n_i),
        .level_o (master_clear_pin_n_q)
    );

    power_up_timer #(.PERIODS(POWER_UP_TIMER_PERIODS)) u_power_up_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (ptif)
    );

    // reset sources; the detector rearms power-on below its range
    assign por_act   = por_q || (bor_en_r && range_low_q);
    assign bor_act   = bor_en_r && bor_low_q && !por_act;
    assign master_clear_pin_n_act  = master_clear_input_enable_i && !master_clear_pin_n_q;
    assign int_reset = (state_r != S_RUN) || master_clear_pin_n_act
                       || watchdog_timeout_i || reset_instr_i;

    // timer held in restart during supply resets; enable is its own fuse
    assign ptif.restart = (state_r == S_POWERON) || (state_r == S_BROWNOUT);
    assign ptif.enable  = power_up_timer_enable_i;

    // reset sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_POWERON:  state_nxt = por_act ? S_POWERON : (bor_act ? S_BROWNOUT : S_TIMER);
            S_BROWNOUT: state_nxt = bor_act ? S_BROWNOUT : S_TIMER;
            S_TIMER:    state_nxt = ptif.busy ? S_TIMER : S_RUN;
            S_RUN:      state_nxt = S_RUN;
            default:    state_nxt = S_POWERON;
        endcase
        if (por_act) begin
            state_nxt = S_POWERON;
        end else if (bor_act) begin
            state_nxt = S_BROWNOUT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_POWERON;
        end else begin
            state_r <= state_nxt;
        end
    end

    // detector enable per mode; soft mode follows bit 6, mode 10 drops in sleep
    always_comb begin
        case (brownout_mode_field)
            `BOR_MODE_OFF:     bor_en_nxt = 1'b0;
            `BOR_MODE_SOFT:    bor_en_nxt = soft_bor_en_r;
            `BOR_MODE_NOSLEEP: bor_en_nxt = !sleep_mode_i;
            `BOR_MODE_ALWAYS:  bor_en_nxt = 1'b1;
            default:           bor_en_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bor_en_r <= 1'b0;
        end else begin
            bor_en_r <= bor_en_nxt;
        end
    end

    // single-cycle ack one edge after the request; a write lands on the next edge, where ack is sampled high
    assign req       = wb_cyc_i && wb_stb_i;
    assign hit       = (wb_adr_i[7:`RCC_WORD_BITS] == 6'(`RCC_REG_OFFSET >> `RCC_WORD_BITS));
    assign bus_write = req && ack_r && wb_we_i && hit && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    // unmapped words read as zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            dat_r <= hit ? {24'h00_0000, rcc_read} : 32'h0000_0000;
        end
    end

    // bit 6 only reads back in soft mode; bit 5 is always zero
    always_comb begin
        rcc_read = 8'h00;
        rcc_read[`RCC_BIT_PRIO_EN]     = prio_en_r;
        rcc_read[`RCC_BIT_SOFT_BOR_EN] = soft_bor_en_r
                                         && brownout_mode_field == `BOR_MODE_SOFT;
        rcc_read[`RCC_BIT_UNUSED]      = 1'b0;
        rcc_read[`RCC_BIT_RESET_INSTR] = reset_instr_flag_n_r;
        rcc_read[`RCC_BIT_WDT_TIMEOUT] = watchdog_timeout_flag_n_r;
        rcc_read[`RCC_BIT_POWERDOWN]   = powerdown_flag_n_r;
        rcc_read[`RCC_BIT_POWERON]     = poweron_flag_n_r;
        rcc_read[`RCC_BIT_BROWNOUT]    = brownout_flag_n_r;
    end

    // cause flags: software write first, hardware events after it so that
    // an event landing on the write edge is never lost
    always_ff @(posedge clk_i) begin
        if (rst_i || por_act) begin
            prio_en_r                 <= `RCC_RST_PRIO_EN;
            soft_bor_en_r             <= (brownout_mode_field == `BOR_MODE_SOFT);
            reset_instr_flag_n_r      <= `RCC_RST_RESET_INSTR;
            watchdog_timeout_flag_n_r <= `RCC_RST_WDT_TIMEOUT;
            powerdown_flag_n_r        <= `RCC_RST_POWERDOWN;
            poweron_flag_n_r          <= `RCC_RST_POWERON;
            brownout_flag_n_r         <= `RCC_RST_BROWNOUT;
        end else begin
            if (bus_write) begin
                prio_en_r            <= wb_dat_i[`RCC_BIT_PRIO_EN];
                if (brownout_mode_field == `BOR_MODE_SOFT) begin
                    soft_bor_en_r <= wb_dat_i[`RCC_BIT_SOFT_BOR_EN];
                end
                reset_instr_flag_n_r <= wb_dat_i[`RCC_BIT_RESET_INSTR];
                poweron_flag_n_r     <= wb_dat_i[`RCC_BIT_POWERON];
                brownout_flag_n_r    <= wb_dat_i[`RCC_BIT_BROWNOUT];
                // watchdog and power-down positions are not written
            end
            if (bor_act) begin
                brownout_flag_n_r         <= 1'b0;
                reset_instr_flag_n_r      <= `RCC_RST_RESET_INSTR;
                watchdog_timeout_flag_n_r <= `RCC_RST_WDT_TIMEOUT;
                powerdown_flag_n_r        <= `RCC_RST_POWERDOWN;
                soft_bor_en_r             <= (brownout_mode_field == `BOR_MODE_SOFT);
            end
            if (int_reset) begin
                prio_en_r <= 1'b0;
            end
            if (watchdog_clear_instruction_i) begin
                watchdog_timeout_flag_n_r <= 1'b1;
                powerdown_flag_n_r        <= 1'b1;
            end
            if (sleep_instr_i) begin
                watchdog_timeout_flag_n_r <= 1'b1;
                powerdown_flag_n_r        <= 1'b0;
            end
            if (watchdog_timeout_i) begin
                watchdog_timeout_flag_n_r <= 1'b0;
            end
            if (reset_instr_i) begin
                reset_instr_flag_n_r <= 1'b0;
            end
        end
    end

    // registered outputs; the pin has no driver at all, only a pull-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_reset_r <= 1'b1;
            pullup_r       <= 1'b1;
            master_clear_pin_n_dig_r     <= 1'b1;
        end else begin
            device_reset_r <= int_reset;
            pullup_r       <= master_clear_input_enable_i;
            master_clear_pin_n_dig_r     <= master_clear_pin_n_q;
        end
    end

    assign wb_ack_o                 = ack_r;
    assign wb_dat_o                 = dat_r;
    assign device_reset_o           = device_reset_r;
    assign priority_levels_enable_o = prio_en_r;
    assign brownout_detect_enable_o = bor_en_r;
    assign master_clear_pullup_en_o = pullup_r;
    assign master_clear_digital_o   = master_clear_pin_n_dig_r;

    a_por_flags_load: assert property (@(posedge clk_i) disable iff (rst_i)
        por_act |=> !poweron_flag_n_r && !brownout_flag_n_r && reset_instr_flag_n_r
                    && watchdog_timeout_flag_n_r && powerdown_flag_n_r && !prio_en_r)
        else $error("power-on flag values wrong");
    a_wdt_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        watchdog_timeout_i && !por_act |=> !watchdog_timeout_flag_n_r)
        else $error("watchdog time-out flag not cleared");
    a_sleep_clears_pd: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_instr_i && !por_act && !bor_act && !watchdog_clear_instruction_i
        |=> !powerdown_flag_n_r)
        else $error("power-down flag not cleared by sleep");
    a_instr_clears_ri: assert property (@(posedge clk_i) disable iff (rst_i)
        reset_instr_i && !por_act
        |=> !reset_instr_flag_n_r && device_reset_o)
        else $error("reset instruction flag not cleared");
    a_bor_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        bor_act |=> !brownout_flag_n_r && state_r == S_BROWNOUT)
        else $error("brown-out did not clear flag or enter reset");
    a_soft_brownout_enable_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !ack_r && hit && brownout_mode_field != `BOR_MODE_SOFT
        |=> wb_ack_o && wb_dat_o[`RCC_BIT_SOFT_BOR_EN] == 1'b0)
        else $error("soft brown-out bit read non-zero outside soft mode");
    a_bor_enable_map: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> brownout_detect_enable_o == ($past(brownout_mode_field) == `BOR_MODE_ALWAYS
        || ($past(brownout_mode_field) == `BOR_MODE_NOSLEEP && !$past(sleep_mode_i))
        || ($past(brownout_mode_field) == `BOR_MODE_SOFT && $past(soft_bor_en_r))))
        else $error("brown-out detect enable does not follow mode");
    a_master_clear_pin_n_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
        !master_clear_input_enable_i && state_r == S_RUN && !watchdog_timeout_i
        && !reset_instr_i |=> !device_reset_o)
        else $error("disabled master clear still resets");
    a_timer_holds_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == S_TIMER |=> device_reset_o)
        else $error("reset released while power-up timer runs");
    a_ro_bits_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_write && !por_act && !bor_act && !watchdog_timeout_i && !sleep_instr_i
        && !watchdog_clear_instruction_i
        |=> $stable(watchdog_timeout_flag_n_r) && $stable(powerdown_flag_n_r))
        else $error("write changed a read-only flag");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

//--- master_clear_pin_n_partner.sv
// external reset circuit: a button that pulls the master clear line low
module master_clear_pin_n_partner (
    input  wire logic clk_i,
    input  wire logic press_i,
    input  wire logic pullup_en_i,
    output logic      pin_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_r = 1'b0;
    // a floating line with no pull-up gives no stable value
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end
    // pressed drives low; released line sits at the weak pull-up level when the pull-up is enabled
    assign pin_n_o = press_i ? 1'b0 : (pullup_en_i ? 1'b1 : float_r);
endmodule

//--- tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rcc_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0;
    logic [7:0]        wb_adr_i = 8'h00;
    logic [31:0]       wb_dat_i = 32'h0;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              bor_low = 1'b0;
    logic              press = 1'b0;
    logic              pin_n;
    logic [3:0]        ev = 4'h0;
    logic              sleep_mode = 1'b0;
    cfg_byte_t         cfg = 8'h02;
    logic              master_clear_pin_n_en = 1'b1;
    logic              tmr_en = 1'b1;
    logic              dev_rst, prio, det_en, pull_en, dig;
    logic              por_p = 1'b0;
    logic              rng_low = 1'b0;
    int                n_rst_cyc = 0;
    int                n_mismatch = 0;
    int                total_checks = 0;
    int                cyc = 0;
    logic [7:0]        rd;

    reset_cause_and_brownout_control #(.POWER_UP_TIMER_PERIODS(2)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .por_pulse_i(por_p),
        .supply_below_bor_i(bor_low), .supply_below_bor_range_i(rng_low),
        .master_clear_pin_n_i(pin_n), .watchdog_timeout_i(ev[0]), .reset_instr_i(ev[1]),
        .watchdog_clear_instruction_i(ev[2]), .sleep_instr_i(ev[3]),
        .sleep_mode_i(sleep_mode), .brownout_config_byte_i(cfg),
        .master_clear_input_enable_i(master_clear_pin_n_en), .power_up_timer_enable_i(tmr_en),
        .device_reset_o(dev_rst), .priority_levels_enable_o(prio),
        .brownout_detect_enable_o(det_en), .master_clear_pullup_en_o(pull_en),
        .master_clear_digital_o(dig));
    master_clear_pin_n_partner btn (.clk_i(clk_i), .press_i(press), .pullup_en_i(pull_en), .pin_n_o(pin_n));

    // clock, reset cycle counter and hang guard
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (dev_rst === 1'b1) n_rst_cyc <= n_rst_cyc + 1;
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle: request held up to the edge that samples ack high,
    // data taken and request released at that same edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o[7:0];
        if (n >= 50) chk("ack", 8'h0, 8'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] exp);
        wb(1'b0, 8'h00, 8'h00);
        chk("reg", rd, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev[i] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // cycles until the combined reset falls, bounded
    task automatic rel_wait(output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (dev_rst !== 1'b0 && n < 2000);
    endtask
    task automatic t_events();
        rdc(8'h5c);
        wb(1'b1, 8'h00, 8'hff);
        rdc(8'hdf);
        chk("prio", {7'h0, prio}, 8'h01);
        pulse(0);
        rdc(8'h57);
        pulse(3);
        rdc(8'h5b);
        pulse(2);
        rdc(8'h5f);
        pulse(1);
        rdc(8'h4f);
        wb(1'b1, 8'h04, 8'h00);
        chk("unmapped", rd, 8'h00);
        rdc(8'h4f);
    endtask
    task automatic t_brownout(input logic te, input logic [7:0] exp);
        int n;
        @(posedge clk_i);
        tmr_en <= te;
        bor_low <= 1'b1;
        repeat (40) @(posedge clk_i);
        bor_low <= 1'b0;
        chk("bor rst", {7'h0, dev_rst}, 8'h01);
        rel_wait(n);
        chk("power_up_timer", {7'h0, te ? n >= 600 : n < 100}, 8'h01);
        rdc(exp);
    endtask
    // a glitch is filtered, a long press resets; disabled input is only a digital pin
    task automatic t_master_clear_pin_n(input logic en, input int len, input logic exp);
        int n;
        int base;
        @(posedge clk_i);
        master_clear_pin_n_en <= en;
        repeat (3) @(posedge clk_i);
        base = n_rst_cyc;
        chk("pullup", {7'h0, pull_en}, {7'h0, en});
        press <= 1'b1;
        repeat (len) @(posedge clk_i);
        // filtered pin level drops only for presses longer than the 20-cycle filter
        chk("digital", {7'h0, dig}, {7'h0, len < 20});
        press <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("pin rst", {7'h0, n_rst_cyc != base}, {7'h0, exp});
        rel_wait(n);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_i);
            cfg <= {5'h0, m[1:0], 1'b0};
            repeat (4) @(posedge clk_i);
            chk("det", {7'h0, det_en}, {7'h0, m != 0});
            wb(1'b0, 8'h00, 8'h00);
            chk("sbor", {7'h0, rd[6]}, {7'h0, m == 1});
        end
        sleep_mode <= 1'b1;
        cfg <= 8'h04;
        repeat (4) @(posedge clk_i);
        chk("det sleep", {7'h0, det_en}, 8'h00);
        sleep_mode <= 1'b0;
        cfg <= 8'h02;
        wb(1'b1, 8'h00, 8'h1e);
        repeat (4) @(posedge clk_i);
        chk("det soft", {7'h0, det_en}, 8'h00);
        rdc(8'h1e);
    endtask
    // range-low rearms power-on only with the detector on; a power-on pulse reloads all
    task automatic t_por();
        int n;
        @(posedge clk_i);
        rng_low <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("rng off", {7'h0, dev_rst}, 8'h00);
        cfg <= 8'h06;
        repeat (8) @(posedge clk_i);
        chk("rng on", {7'h0, dev_rst}, 8'h01);
        rng_low <= 1'b0;
        rel_wait(n);
        rdc(8'h1c);
        wb(1'b1, 8'h00, 8'h93);
        rdc(8'h9f);
        por_p <= 1'b1;
        repeat (4) @(posedge clk_i);
        por_p <= 1'b0;
        repeat (4) @(posedge clk_i);
        rel_wait(n);
        rdc(8'h1c);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        int n;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rel_wait(n);
        chk("por power_up_timer", {7'h0, n >= 600}, 8'h01);
        t_events();
        t_brownout(1'b1, 8'h5e);
        t_brownout(1'b0, 8'h5e);
        t_master_clear_pin_n(1'b1, 10, 1'b0);
        t_master_clear_pin_n(1'b1, 40, 1'b1);
        t_master_clear_pin_n(1'b1, 3, 1'b0);
        // disabled case last: without the pull-up the released line floats
        t_master_clear_pin_n(1'b0, 40, 1'b0);
        t_modes();
        t_por();
        final_report();
    end
endmodule
